// >>> dv/ebt_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// External peripheral answering reads on the data lines
// ---------------------------------------------------------------
module ebt_periph_model #(
  parameter int unsigned DW = 16
) (
  input  wire logic          clk,
  input  wire logic          chip_sel_n,
  input  wire logic          read_strobe_n,
  input  wire logic [DW-1:0] read_word,
  output var  logic [DW-1:0] data_out
);
  logic [DW-1:0] idle_q = '0;

  // Released lines toggle every cycle, so a late capture sees garbage
  always_ff @(posedge clk) begin
    idle_q <= ~data_out;
  end

  // Word is driven only while selected and strobed for a read
  always_comb begin
    data_out = (!chip_sel_n && !read_strobe_n) ? read_word : idle_q;
  end
endmodule // ebt_periph_model

`default_nettype wire

// >>> dv/test_ebt_async_timing.sv
`timescale 1ns/1ps
`default_nettype none

module test_ebt_async_timing
  import ebt_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [1:0]  access_mode = 2'h0;
  logic [1:0]  a_len = 2'h0, d_len = 2'h0, h_len = 2'h0;
  logic [3:0]  s_len = 4'h0, r_len = 4'h0;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000, periph_word = 16'h0000, ext_ad_i;
  logic        req_ready_q, rdata_valid_q, address_latch_pulse, ext_ad_oe_q, chip_sel_n_q;
  logic [15:0] rdata_q, ext_ad_o_q;
  logic [23:0] ext_addr_q;
  logic        mrd_n, mwr_n, srd_n, swr_n, ds_n, rnw;
  int          error_cnt = 0, total_checks = 0;
  localparam int DIV = 2;

  always #25 clk = ~clk;

  // Bus clock of two system clocks, so every phase is judged in whole bus periods
  ebt_async_timing #(.BUS_DIV(DIV)) DUT (
    .clk(clk), .srst(srst), .access_mode(access_mode),
    .address_phase_len(a_len), .data_setup_phase_len(d_len), .strobe_phase_len(s_len),
    .hold_phase_len(h_len), .recovery_phase_len(r_len),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready_q(req_ready_q), .rdata_valid_q(rdata_valid_q), .rdata_q(rdata_q),
    .address_latch_pulse(address_latch_pulse), .ext_addr_q(ext_addr_q),
    .ext_ad_o_q(ext_ad_o_q), .ext_ad_oe_q(ext_ad_oe_q), .ext_ad_i(ext_ad_i),
    .chip_sel_n_q(chip_sel_n_q), .mux_read_strobe_n_q(mrd_n), .mux_write_strobe_n_q(mwr_n),
    .simplex_read_strobe_n(srd_n), .simplex_write_strobe_n(swr_n),
    .single_data_strobe_n(ds_n), .read_not_write_q(rnw));

  // Far side sees the read strobe of whichever style is active
  ebt_periph_model #(.DW(16)) u_periph (
    .clk(clk), .chip_sel_n(chip_sel_n_q),
    .read_strobe_n(mrd_n & srd_n & (ds_n | !rnw)),
    .read_word(periph_word), .data_out(ext_ad_i));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // ---------------------------------------------------------------
  // One access, measured phase by phase at the falling edges
  // ---------------------------------------------------------------
  task automatic run_access(input string nm, input logic [1:0] md, input logic wr,
                            input int a, input int d, input int s, input int h, input int r);
    int          cnt [5];
    int          ph, lat, bad, rv, idx, k;
    logic        mux, sel;
    logic [4:0]  stb;
    cnt = '{0, 0, 0, 0, 0};
    ph = 0; lat = 0; bad = 0; rv = 0;
    mux = (md != 2'h1);
    idx = (md == 2'h1) ? (wr ? 1 : 2) : (md == 2'h2) ? 0 : (wr ? 3 : 4);
    for (k = 0; k < 50 && req_ready_q !== 1'b1; k++) @(negedge clk);
    access_mode = md; req_write = wr;
    a_len = 2'(a - 1); d_len = 2'(d - 1); s_len = 4'(s - 1); h_len = 2'(h - 1); r_len = 4'(r - 1);
    req_addr = req_addr + 24'h13579B;
    req_wdata = req_wdata ^ 16'h5AC3;
    periph_word = ~req_wdata;
    req_valid = 1'b1;
    // Hold the request until a bus period boundary takes it
    for (k = 0; k < 8 && req_ready_q === 1'b1; k++) @(negedge clk);
    req_valid = 1'b0;
    for (k = 0; k < 200; k++) begin
      stb = {mrd_n, mwr_n, srd_n, swr_n, ds_n};
      sel = stb[idx];
      stb[idx] = 1'b1;
      if (ph == 0 && chip_sel_n_q === 1'b0) ph = 1;
      if (ph == 1 && sel === 1'b0) ph = 2;
      if (ph == 2 && sel === 1'b1) ph = 3;
      if (ph == 3 && chip_sel_n_q === 1'b1) ph = 4;
      if (req_ready_q === 1'b1) break;
      cnt[ph]++;
      if (address_latch_pulse === 1'b1) lat++;
      if (rdata_valid_q === 1'b1) rv++;
      if (stb !== 5'h1F) bad++;
      if (mux && ph == 0 && (ext_ad_oe_q !== 1'b1 || ext_ad_o_q !== req_addr[15:0])) bad++;
      if (ph inside {[1:3]} && ext_addr_q !== req_addr) bad++;
      if (wr && ph inside {[1:3]} && (ext_ad_oe_q !== 1'b1 || ext_ad_o_q !== req_wdata)) bad++;
      // Direction stands through the access; a read leaves the data lines undriven from select through hold
      if (ph < 4 && rnw !== !wr) bad++;
      if (!wr && ph inside {[1:3]} && ext_ad_oe_q !== 1'b0) bad++;
      @(negedge clk);
    end
    check("latch width", mux ? a * DIV : 0, lat);
    check("address to select", (mux ? a + 1 : a) * DIV, cnt[0]);
    check("setup lead", d * DIV, cnt[1]);
    check("strobe width", s * DIV, cnt[2]);
    check("hold length", h * DIV, cnt[3]);
    check("recovery gap", r * DIV, cnt[4]);
    check("lines held", 0, bad);
    if (!wr) begin
      check("read pulses", 1, rv);
      check("read data", {16'h0000, periph_word}, {16'h0000, rdata_q});
    end
    $display("test %s done", nm);
  endtask

  // ---------------------------------------------------------------
  // Scenarios, one per style and direction plus an unused-code write, boundary lengths for the multiplexed pair
  // ---------------------------------------------------------------
  task automatic t_mux_wr_min();  run_access("mux_wr_min", 2'h0, 1'b1, 1, 1, 1, 1, 1);   endtask
  task automatic t_mux_rd_max();  run_access("mux_rd_max", 2'h0, 1'b0, 4, 4, 16, 4, 16); endtask
  task automatic t_sx_wr();       run_access("sx_wr", 2'h1, 1'b1, 3, 2, 5, 4, 2);        endtask
  task automatic t_sx_rd();       run_access("sx_rd", 2'h1, 1'b0, 2, 3, 1, 2, 7);        endtask
  task automatic t_ds_wr();       run_access("ds_wr", 2'h2, 1'b1, 4, 1, 16, 3, 1);       endtask
  task automatic t_ds_rd();       run_access("ds_rd", 2'h2, 1'b0, 1, 4, 2, 1, 16);       endtask
  task automatic t_mode3_wr();    run_access("mode3_wr", 2'h3, 1'b1, 2, 2, 2, 2, 2);     endtask

  // Stimulus: reset held six cycles, then back-to-back accesses
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    t_mux_wr_min();
    t_mux_rd_max();
    t_sx_wr();
    t_sx_rd();
    t_ds_wr();
    t_ds_rd();
    t_mode3_wr();
    conclude();
  end

  // Watchdog well beyond seven accesses of at most a hundred cycles each
  initial begin
    #(5000 * 50);
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    conclude();
  end
endmodule // test_ebt_async_timing

`default_nettype wire

// >>> hw/ebt_async_timing.sv
// How it works
// [R1] Multiplexed style drives a latch pulse 1-4 periods, address valid at rise.
// [R2] Address phase length sets the latch pulse width, one to four periods.
// [R3] Address held exactly one period after the latch pulse falls, fixed.
// [R4] Multiplexed chip select goes active one period after latch pulse falls.
// [R5] Write data leads the write strobe fall by the data setup length.
// [R6] Write strobe stays low for the strobe length, 1-16 periods.
// [R7] Write data stays valid for the hold length after the strobe rises.
// [R8] Hold phase keeps chip select, address and write data unchanged.
// [R9] Any data strobe lasts the strobe length; write data present throughout.
// [R10] Multiplexed style inserts a 1-16 period recovery gap between accesses.
// [R11] Every phase length counts expansion bus clock periods.
// [R12] Simplex style never produces the latch pulse.
// [R13] Simplex chip select goes active address phase length after address valid.
// [R14] Simplex write data leads the simplex write strobe fall by 1-4 periods.
// [R15] Simplex write strobe stays low 1-16 periods.
// [R16] Simplex write data stays 1-4 periods after its strobe rises.
// [R17] Simplex style also spaces accesses by a 1-16 period recovery gap.
// [R18] Data-strobe style write data leads the data strobe fall by 1-4 periods.
// [R19] Data-strobe style holds the data strobe low for the strobe length.
// [R20] Phases run address, setup, strobe, hold, recovery, each its own length.
// [R21] Reads capture the data lines as the read strobe ends.
`timescale 1ns/1ps
`default_nettype none

module ebt_async_timing
  import ebt_pkg::*;
#(
  parameter int unsigned ADDR_W  = EBT_ADDR_W_DEFAULT,
  parameter int unsigned DATA_W  = EBT_DATA_W_DEFAULT,
  parameter int unsigned BUS_DIV = EBT_BUS_DIV_DEFAULT
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Configuration, sampled when an access is accepted
  input  wire logic [1:0]                 access_mode,
  input  wire logic [EBT_SHORT_LEN_W-1:0] address_phase_len,
  input  wire logic [EBT_SHORT_LEN_W-1:0] data_setup_phase_len,
  input  wire logic [EBT_LONG_LEN_W-1:0]  strobe_phase_len,
  input  wire logic [EBT_SHORT_LEN_W-1:0] hold_phase_len,
  input  wire logic [EBT_LONG_LEN_W-1:0]  recovery_phase_len,
  // Access request and answer
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic [ADDR_W-1:0]          req_addr,
  input  wire logic [DATA_W-1:0]          req_wdata,
  output var  logic                       req_ready_q,
  output var  logic                       rdata_valid_q,
  output var  logic [DATA_W-1:0]          rdata_q,
  // Expansion bus pins
  output var  logic                       address_latch_pulse,
  output var  logic [ADDR_W-1:0]          ext_addr_q,
  output var  logic [DATA_W-1:0]          ext_ad_o_q,
  output var  logic                       ext_ad_oe_q,
  input  wire logic [DATA_W-1:0]          ext_ad_i,
  output var  logic                       chip_sel_n_q,
  output var  logic                       mux_read_strobe_n_q,
  output var  logic                       mux_write_strobe_n_q,
  output var  logic                       simplex_read_strobe_n,
  output var  logic                       simplex_write_strobe_n,
  output var  logic                       single_data_strobe_n,
  output var  logic                       read_not_write_q
);

  // ---------------------------------------------------------------
  // Bus clock enable
  // ---------------------------------------------------------------
  logic tick;

  ebt_tick_div #(
    .DIV    (BUS_DIV)
  ) u_tick_div (
    .clk    (clk),
    .srst   (srst),
    .tick_q (tick)
  );

  // ---------------------------------------------------------------
  // Sequencer state and latched access
  // ---------------------------------------------------------------
  ebt_state_e                   state_q;
  ebt_state_e                   state_d;
  logic [EBT_LONG_LEN_W-1:0]    cnt_q;
  logic [EBT_LONG_LEN_W-1:0]    cnt_d;
  ebt_mode_e                    mode_q;
  logic                         write_q;
  logic [ADDR_W-1:0]            addr_q;
  logic [DATA_W-1:0]            wdata_q;
  logic [EBT_SHORT_LEN_W-1:0]   len_addr_q;
  logic [EBT_SHORT_LEN_W-1:0]   len_setup_q;
  logic [EBT_LONG_LEN_W-1:0]    len_strobe_q;
  logic [EBT_SHORT_LEN_W-1:0]   len_hold_q;
  logic [EBT_LONG_LEN_W-1:0]    len_recov_q;
  logic                         accept;
  logic                         phase_end;

  // Widen a short length field to the counter width
  function automatic logic [EBT_LONG_LEN_W-1:0] widen(
    input logic [EBT_SHORT_LEN_W-1:0] v
  );
    widen = {{(EBT_LONG_LEN_W-EBT_SHORT_LEN_W){1'b0}}, v};
  endfunction

  // Styles that share the lines and emit a latch pulse
  function automatic logic is_muxed(input ebt_mode_e m);
    is_muxed = (m != EBT_MODE_SIMPLEX);
  endfunction

  // Decode the style; the unused code falls back to plain multiplexed
  function automatic ebt_mode_e decode_mode(input logic [1:0] m);
    case (m)
      2'h1:    decode_mode = EBT_MODE_SIMPLEX;
      2'h2:    decode_mode = EBT_MODE_DS_MUX;
      default: decode_mode = EBT_MODE_MUX;
    endcase
  endfunction

  // Requests are only taken on a bus period boundary while idle
  assign accept    = tick && req_ready_q && req_valid;
  // A phase ends on the tick that finishes its last period
  assign phase_end = tick && (cnt_q == EBT_CNT_RESET);  // [R11]

  // Next phase and its length; each phase lasts (field + 1) periods
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      EBT_ST_IDLE: begin
        if (accept) begin
          state_d = EBT_ST_ADDR;  // [R20]
          cnt_d   = widen(address_phase_len);  // [R2] [R13]
        end
      end
      EBT_ST_ADDR: begin
        if (phase_end) begin
          if (is_muxed(mode_q)) begin
            state_d = EBT_ST_LHOLD;
            cnt_d   = widen(EBT_LATCH_HOLD_LEN);  // [R3]
          end else begin
            state_d = EBT_ST_SETUP;  // [R12]
            cnt_d   = widen(len_setup_q);
          end
        end
      end
      EBT_ST_LHOLD: begin
        if (phase_end) begin
          state_d = EBT_ST_SETUP;  // [R4]
          cnt_d   = widen(len_setup_q);  // [R5] [R14] [R18]
        end
      end
      EBT_ST_SETUP: begin
        if (phase_end) begin
          state_d = EBT_ST_STROBE;
          cnt_d   = len_strobe_q;  // [R6] [R15] [R19]
        end
      end
      EBT_ST_STROBE: begin
        if (phase_end) begin
          state_d = EBT_ST_HOLD;
          cnt_d   = widen(len_hold_q);  // [R7] [R16]
        end
      end
      EBT_ST_HOLD: begin
        if (phase_end) begin
          state_d = EBT_ST_RECOV;
          cnt_d   = len_recov_q;  // [R10] [R17]
        end
      end
      EBT_ST_RECOV: begin
        if (phase_end) begin
          state_d = EBT_ST_IDLE;
        end
      end
      default: begin
        state_d = EBT_ST_IDLE;
        cnt_d   = EBT_CNT_RESET;
      end
    endcase
    // Count down within a phase, one step per bus period
    if (tick && (state_d == state_q) && (cnt_q != EBT_CNT_RESET)) begin
      cnt_d = cnt_q - EBT_LONG_LEN_W'(1);  // [R11]
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ebt_state_e'(EBT_RESET_STATE);
      cnt_q   <= EBT_CNT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Latch the access and its timing so a mid-access change cannot warp it
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q       <= EBT_MODE_MUX;
      write_q      <= 1'b0;
      addr_q       <= '0;
      wdata_q      <= '0;
      len_addr_q   <= '0;
      len_setup_q  <= '0;
      len_strobe_q <= '0;
      len_hold_q   <= '0;
      len_recov_q  <= '0;
    end else if (accept) begin
      mode_q       <= decode_mode(access_mode);
      write_q      <= req_write;
      addr_q       <= req_addr;
      wdata_q      <= req_wdata;
      len_addr_q   <= address_phase_len;
      len_setup_q  <= data_setup_phase_len;
      len_strobe_q <= strobe_phase_len;
      len_hold_q   <= hold_phase_len;
      len_recov_q  <= recovery_phase_len;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers, registered from the next state so pins track state_q
  // ---------------------------------------------------------------
  logic       in_addr_d;
  logic       in_cs_d;
  logic       in_strobe_d;
  ebt_mode_e  mode_d;
  logic       write_d;

  assign mode_d      = accept ? decode_mode(access_mode) : mode_q;
  assign write_d     = accept ? req_write : write_q;
  // Address lines stand from the address phase until hold ends
  assign in_addr_d   = (state_d != EBT_ST_IDLE) && (state_d != EBT_ST_RECOV);
  // Chip select covers setup, strobe and hold
  assign in_cs_d     = (state_d == EBT_ST_SETUP) || (state_d == EBT_ST_STROBE)
                    || (state_d == EBT_ST_HOLD);
  assign in_strobe_d = (state_d == EBT_ST_STROBE);

  // Latch pulse and address lines
  always_ff @(posedge clk) begin
    if (srst) begin
      address_latch_pulse <= 1'b0;
      ext_addr_q          <= '0;
    end else begin
      // High only for the address phase in a shared-line style
      address_latch_pulse <= (state_d == EBT_ST_ADDR) && is_muxed(mode_d);  // [R1] [R12]
      if (accept) begin
        ext_addr_q <= req_addr;  // [R8] [R13]
      end else if (!in_addr_d) begin
        ext_addr_q <= '0;
      end
    end
  end

  // Shared address/data lines; write data stands from setup through hold
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_ad_o_q  <= '0;
      ext_ad_oe_q <= 1'b0;
    end else begin
      if ((state_d == EBT_ST_ADDR) || (state_d == EBT_ST_LHOLD)) begin
        ext_ad_o_q  <= is_muxed(mode_d) ? (accept ? req_addr[DATA_W-1:0]
                                                  : addr_q[DATA_W-1:0]) : '0;
        ext_ad_oe_q <= is_muxed(mode_d);  // [R1] [R3]
      end else if (in_cs_d && write_d) begin
        ext_ad_o_q  <= wdata_q;  // [R5] [R7] [R9] [R14] [R16] [R18]
        ext_ad_oe_q <= 1'b1;  // [R8]
      end else begin
        ext_ad_o_q  <= '0;
        ext_ad_oe_q <= 1'b0;
      end
    end
  end

  // Chip select and the strobe of the selected style
  always_ff @(posedge clk) begin
    if (srst) begin
      chip_sel_n_q           <= 1'b1;
      mux_read_strobe_n_q    <= 1'b1;
      mux_write_strobe_n_q   <= 1'b1;
      simplex_read_strobe_n  <= 1'b1;
      simplex_write_strobe_n <= 1'b1;
      single_data_strobe_n   <= 1'b1;
      read_not_write_q       <= 1'b1;
    end else begin
      chip_sel_n_q           <= !in_cs_d;  // [R4] [R8] [R13]
      mux_read_strobe_n_q    <= !(in_strobe_d && mode_d == EBT_MODE_MUX && !write_d);
      mux_write_strobe_n_q   <= !(in_strobe_d && mode_d == EBT_MODE_MUX && write_d);  // [R6]
      simplex_read_strobe_n  <= !(in_strobe_d && mode_d == EBT_MODE_SIMPLEX && !write_d);
      simplex_write_strobe_n <= !(in_strobe_d && mode_d == EBT_MODE_SIMPLEX && write_d);  // [R15]
      single_data_strobe_n   <= !(in_strobe_d && mode_d == EBT_MODE_DS_MUX);  // [R9] [R19]
      // Direction only matters to the data-strobe style; parks high when idle
      read_not_write_q       <= in_addr_d ? !write_d : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read capture and request handshake
  // ---------------------------------------------------------------
  // Sampling in the last clock of the strobe gives the widest setup margin
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q       <= '0;
      rdata_valid_q <= 1'b0;
      req_ready_q   <= 1'b0;
    end else begin
      rdata_valid_q <= 1'b0;
      if ((state_q == EBT_ST_STROBE) && phase_end && !write_q) begin
        rdata_q       <= ext_ad_i;  // [R21]
        rdata_valid_q <= 1'b1;
      end
      req_ready_q <= (state_d == EBT_ST_IDLE);  // [R10] [R17]
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Periods completed within the current phase
  logic [4:0] ph_periods_q;
  logic       leaving;

  assign leaving = (state_q != EBT_ST_IDLE) && (state_d != state_q);

  always_ff @(posedge clk) begin
    if (srst || (state_d != state_q)) begin
      ph_periods_q <= 5'h00;
    end else if (tick) begin
      ph_periods_q <= ph_periods_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  latch_simplex_a: assert property (address_latch_pulse |-> mode_q != EBT_MODE_SIMPLEX) // [R12]
    else $error("latch pulse in simplex style");
  latch_width_a: assert property (leaving && state_q == EBT_ST_ADDR |-> // [R2]
      ph_periods_q == 5'(len_addr_q)) else $error("latch pulse width wrong");
  latch_hold_a: assert property (leaving && state_q == EBT_ST_LHOLD |-> // [R3]
      ph_periods_q == 5'h00 && !address_latch_pulse && ext_ad_oe_q)
    else $error("address hold after latch not one period");
  setup_len_a: assert property (leaving && state_q == EBT_ST_SETUP |-> // [R5]
      ph_periods_q == 5'(len_setup_q)) else $error("setup phase length wrong");
  strobe_len_a: assert property (leaving && state_q == EBT_ST_STROBE |-> // [R6]
      ph_periods_q == 5'(len_strobe_q)) else $error("strobe phase length wrong");
  hold_len_a: assert property (leaving && state_q == EBT_ST_HOLD |-> // [R7]
      ph_periods_q == 5'(len_hold_q) ##1 chip_sel_n_q) else $error("hold phase length wrong");
  recov_len_a: assert property (leaving && state_q == EBT_ST_RECOV |-> // [R10]
      ph_periods_q == 5'(len_recov_q)) else $error("recovery gap wrong");
  strobe_cs_a: assert property (!single_data_strobe_n || !mux_write_strobe_n_q // [R9]
      || !simplex_write_strobe_n |-> !chip_sel_n_q && ext_ad_oe_q == write_q)
    else $error("strobe without select or write data");
  phase_order_a: assert property ($changed(state_q) && state_q == EBT_ST_STROBE |-> // [R20]
      $past(state_q) == EBT_ST_SETUP) else $error("strobe not after setup");
  read_capture_a: assert property (rdata_valid_q |-> $past(state_q) == EBT_ST_STROBE // [R21]
      && state_q == EBT_ST_HOLD && !write_q) else $error("read captured off strobe end");

  mux_write_c: cover property (!mux_write_strobe_n_q ##[1:300] rdata_valid_q == 1'b0
      && state_q == EBT_ST_RECOV);
  simplex_read_c: cover property (!simplex_read_strobe_n ##[1:300] rdata_valid_q);
  ds_write_c: cover property (!single_data_strobe_n && !read_not_write_q);
  back_to_back_c: cover property (state_q == EBT_ST_RECOV ##1 state_q == EBT_ST_IDLE
      ##[1:8] state_q == EBT_ST_ADDR);

endmodule // ebt_async_timing

`default_nettype wire

// >>> hw/ebt_pkg.sv
`default_nettype none

package ebt_pkg;

  // ---------------------------------------------------------------
  // Clock and bus clock
  // ---------------------------------------------------------------
  localparam int unsigned EBT_CLK_PERIOD_NS = 50;
  // System clocks per expansion bus clock period
  localparam int unsigned EBT_BUS_DIV_DEFAULT = 2;

  // ---------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------
  localparam int unsigned EBT_ADDR_W_DEFAULT = 24;
  localparam int unsigned EBT_DATA_W_DEFAULT = 16;

  // ---------------------------------------------------------------
  // Phase length fields, each holding (periods - 1)
  // ---------------------------------------------------------------
  localparam int unsigned EBT_SHORT_LEN_W = 2;   // 1..4 periods
  localparam int unsigned EBT_LONG_LEN_W  = 4;   // 1..16 periods
  // Address hold after the latch pulse falls, periods - 1 (fixed one period)
  localparam logic [EBT_SHORT_LEN_W-1:0] EBT_LATCH_HOLD_LEN = 2'h0;

  // ---------------------------------------------------------------
  // Access styles
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EBT_MODE_MUX     = 2'h0,  // Shared lines, latch pulse, read/write strobes
    EBT_MODE_SIMPLEX = 2'h1,  // Separate lines, no latch pulse
    EBT_MODE_DS_MUX  = 2'h2   // Shared lines, latch pulse, single data strobe
  } ebt_mode_e;

  // ---------------------------------------------------------------
  // Access sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EBT_ST_IDLE   = 3'h0,
    EBT_ST_ADDR   = 3'h1,
    EBT_ST_LHOLD  = 3'h2,
    EBT_ST_SETUP  = 3'h3,
    EBT_ST_STROBE = 3'h4,
    EBT_ST_HOLD   = 3'h5,
    EBT_ST_RECOV  = 3'h6
  } ebt_state_e;

  localparam logic [2:0]                 EBT_RESET_STATE = 3'h0;
  localparam logic [EBT_LONG_LEN_W-1:0]  EBT_CNT_RESET   = 4'h0;

endpackage : ebt_pkg

`default_nettype wire

// >>> hw/ebt_tick_div.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Expansion bus clock enable divider
// ---------------------------------------------------------------
module ebt_tick_div
  import ebt_pkg::*;
#(
  parameter int unsigned DIV = EBT_BUS_DIV_DEFAULT
) (
  input  wire logic clk,
  input  wire logic srst,
  output var  logic tick_q
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_q;

  // Free running divider; one enable pulse per bus clock period
  always_ff @(posedge clk) begin
    if (srst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      if (div_q == LAST) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + CW'(1);
      end
      tick_q <= (div_q == LAST);
    end
  end

endmodule // ebt_tick_div

`default_nettype wire
